// ==== design/wsirq_pkg.sv ====
package wsirq_pkg;

   // Command byte layout
   localparam int          CMD_TYPE_MSB  = 7;
   localparam int          CMD_TYPE_LSB  = 5;
   localparam int          CMD_ADDR_MSB  = 4;
   localparam int          CMD_ADDR_LSB  = 0;
   localparam logic [2:0]  CMD_RD_BUF    = 3'h0;
   localparam logic [2:0]  CMD_WR_BUF    = 3'h1;
   localparam logic [2:0]  CMD_RD_REG    = 3'h2;
   localparam logic [2:0]  CMD_WR_REG    = 3'h3;
   localparam logic [2:0]  CMD_OFF       = 3'h4;
   localparam logic [2:0]  CMD_IRQ_CLR   = 3'h5;

   // Register addresses
   localparam logic [4:0]  ADDR_TX_PWR   = 5'h07;
   localparam logic [4:0]  ADDR_STATUS   = 5'h10;

   // Power configuration fields and reset value
   localparam int          PWR_FE_BIT    = 6;
   localparam int          PWR_SEL_BIT   = 5;
   localparam int          PWR_CODE_MSB  = 4;
   localparam logic        PWR_FE_RST    = 1'h1;
   localparam logic        PWR_SEL_RST   = 1'h0;
   localparam logic [4:0]  PWR_CODE_RST  = 5'h10;

   // Status register bit positions
   localparam int          STS_KEY_BIT   = 0;
   localparam int          STS_WAKE_BIT  = 1;
   localparam int          STS_RAM_BIT   = 2;

   // Timing
   localparam int          DEBOUNCE_PERIODS = 8195;
   localparam int          WAKE_DLY_CYC     = 4;
   localparam int          CNT_W            = 14;

   typedef struct packed {
      logic       frontend_cfg_bit;
      logic       power_resistor_select;
      logic [4:0] power_resistor_code;
   } wsirq_pwr_cfg_type;

   typedef struct packed {
      logic key_status;
      logic wake_flag;
      logic ram_supply_lost;
   } wsirq_status_type;

   typedef enum logic [2:0] {
      MODE_OFF    = 3'h1,
      MODE_POWUP  = 3'h2,
      MODE_ACTIVE = 3'h4
   } wsirq_mode_type;

   typedef enum logic [1:0] {
      SRC_NONE = 2'h0,
      SRC_KEY  = 2'h1,
      SRC_WAKE = 2'h2
   } wsirq_src_type;

endpackage : wsirq_pkg

// ==== design/wsirq_logic.sv ====
// Behaviour
// - Select bit zero: TX uses fixed resistor, full duplex uses code; one: code in both TX and full duplex.
// - Five-bit resistor code, reset sixteen, sets output power reduction resistance.
// - Status register at address sixteen, readable over the serial interface.
// - Interrupt raised when wake flag sets or debounced key event occurs.
// - Status read clears wake flag, RAM-supply-lost flag and interrupt.
// - Key status bit is the inverse of the key pin level.
// - Wake flag marks wake-pin rising edge and forces clock-output enable.
// - RAM-supply-lost sets on supply undervoltage and on every OFF-to-IDLE change.
// - RAM-supply-lost clears only when supply is good and status is read.
// - Key pin low wakes device from OFF and turns supplies on.
// - After wake, once supply and oscillator good, set status and interrupt; clock out forced only for a wake-pin source.
// - Key pin high again before wake interrupt keeps device in OFF.
// - Wake pin low again before wake interrupt keeps device in OFF.
// - Releasing a wake input after the wake interrupt never enters OFF mode.
// - Active key edge starts debounce; at 8195 periods update status, interrupt, stop.
// - Another key event before 8195 periods stops the debounce counter.
// - Running debounce counter forces clock-output enable.
// - Interrupt cleared by status read or interrupt-clear command.
// - Active wake-pin rising edge sets wake flag after fixed delay.
// - Interrupt only when wake flag goes zero to one.
// - Wake pin high wakes device from OFF and turns supplies on.
// - Command type in bits seven to five, register address in bits four to zero.
// - Interrupt-clear command drives interrupt output low.
`timescale 1ns/1ps
module wsirq_logic #(
   parameter int DEBOUNCE_CYC = wsirq_pkg::DEBOUNCE_PERIODS
) (
   input  wire logic       core_clk_in,          // Data clock, 25 MHz
   input  wire logic       arst_n_in,            // Async reset, active low
   input  wire logic       cmd_valid_in,         // One-cycle strobe: decoded command byte
   input  wire logic [7:0] cmd_byte_in,          // Command byte
   input  wire logic [7:0] cmd_wdata_in,         // Data byte for register write
   input  wire logic       key_wake_pin_n_in,    // Key wake pin, active low
   input  wire logic       wake_pin_in,          // Wake pin, active high
   input  wire logic       ram_supply_low_in,    // Supply monitor: RAM supply under threshold
   input  wire logic       supply_osc_ready_in,  // Digital supply good and oscillator settled
   input  wire logic       tx_mode_in,           // Transceiver in TX mode
   input  wire logic       full_duplex_mode_in,  // Transceiver in full-duplex mode
   input  wire logic       clk_on_sw_in,         // Clock-output enable as software set it
   output logic      [7:0] rd_data_out,          // Register read data
   output logic            rd_valid_out,         // One-cycle strobe with read data
   output logic            irq_out,              // Interrupt to host, active high level
   output logic            supplies_on_out,      // Internal supplies enabled
   output logic            active_mode_out,      // Digital logic in an active mode
   output logic            clk_out_en_out,       // Effective clock-output enable
   output logic            use_code_resistor_out,// Resistor code applies in current mode
   output logic      [4:0] power_reduce_resistor_out // Resistor code to the power stage
);

   wsirq_pkg::wsirq_pwr_cfg_type pwr_cfg_ff,  nxt_pwr_cfg;
   wsirq_pkg::wsirq_status_type  status_ff,   nxt_status;
   wsirq_pkg::wsirq_mode_type    mode_ff,     nxt_mode;
   wsirq_pkg::wsirq_src_type     src_ff,      nxt_src;
   logic                         irq_ff,      nxt_irq;
   logic                         key_prev_ff, nxt_key_prev;
   logic                         wake_prev_ff, nxt_wake_prev;
   logic                         deb_run_ff,  nxt_deb_run;
   logic [wsirq_pkg::CNT_W-1:0]  deb_cnt_ff,  nxt_deb_cnt;
   logic                         dly_run_ff,  nxt_dly_run;
   logic [wsirq_pkg::CNT_W-1:0]  dly_cnt_ff,  nxt_dly_cnt;
   logic [7:0]                   rd_data_ff,  nxt_rd_data;
   logic                         rd_valid_ff, nxt_rd_valid;

   logic [2:0]                   cmd_type;
   logic [4:0]                   cmd_addr;
   logic                         status_rd;
   logic                         key_edge;
   logic                         wake_rise;

   localparam logic [wsirq_pkg::CNT_W-1:0] DEB_LAST =
      wsirq_pkg::CNT_W'(DEBOUNCE_CYC - 1);
   localparam logic [wsirq_pkg::CNT_W-1:0] DLY_LAST =
      wsirq_pkg::CNT_W'(wsirq_pkg::WAKE_DLY_CYC - 1);

   always_comb begin
      cmd_type  = cmd_byte_in[wsirq_pkg::CMD_TYPE_MSB:wsirq_pkg::CMD_TYPE_LSB];
      cmd_addr  = cmd_byte_in[wsirq_pkg::CMD_ADDR_MSB:wsirq_pkg::CMD_ADDR_LSB];
      status_rd = cmd_valid_in && (cmd_type == wsirq_pkg::CMD_RD_REG)
                  && (cmd_addr == wsirq_pkg::ADDR_STATUS);
      key_edge  = key_wake_pin_n_in != key_prev_ff;
      wake_rise = wake_pin_in && !wake_prev_ff;

      nxt_pwr_cfg   = pwr_cfg_ff;
      nxt_status    = status_ff;
      nxt_mode      = mode_ff;
      nxt_src       = src_ff;
      nxt_irq       = irq_ff;
      nxt_key_prev  = key_wake_pin_n_in;
      nxt_wake_prev = wake_pin_in;
      nxt_deb_run   = deb_run_ff;
      nxt_deb_cnt   = deb_cnt_ff;
      nxt_dly_run   = dly_run_ff;
      nxt_dly_cnt   = dly_cnt_ff;
      nxt_rd_data   = rd_data_ff;
      nxt_rd_valid  = 1'b0;

      // Clears first, so any set below in the same cycle wins
      if (status_rd) begin
         nxt_status.wake_flag = 1'b0;
         nxt_irq              = 1'b0;
         if (!ram_supply_low_in) begin
            nxt_status.ram_supply_lost = 1'b0;
         end
      end
      if (cmd_valid_in && cmd_type == wsirq_pkg::CMD_IRQ_CLR) begin
         nxt_irq = 1'b0;
      end

      if (cmd_valid_in && cmd_type == wsirq_pkg::CMD_RD_REG) begin
         nxt_rd_valid = 1'b1;
         case (cmd_addr)
            wsirq_pkg::ADDR_TX_PWR: nxt_rd_data = {1'b0, pwr_cfg_ff};
            wsirq_pkg::ADDR_STATUS: nxt_rd_data = {5'h00, status_ff.ram_supply_lost,
                                                   status_ff.wake_flag, status_ff.key_status};
            default:                nxt_rd_data = 8'h00;
         endcase
      end
      if (cmd_valid_in && cmd_type == wsirq_pkg::CMD_WR_REG
          && cmd_addr == wsirq_pkg::ADDR_TX_PWR) begin
         nxt_pwr_cfg.frontend_cfg_bit      = cmd_wdata_in[wsirq_pkg::PWR_FE_BIT];
         nxt_pwr_cfg.power_resistor_select = cmd_wdata_in[wsirq_pkg::PWR_SEL_BIT];
         nxt_pwr_cfg.power_resistor_code   = cmd_wdata_in[wsirq_pkg::PWR_CODE_MSB:0];
      end

      if (ram_supply_low_in) begin
         nxt_status.ram_supply_lost = 1'b1;
      end

      case (mode_ff)
         wsirq_pkg::MODE_OFF: begin
            nxt_deb_run = 1'b0;
            nxt_dly_run = 1'b0;
            if (!key_wake_pin_n_in && key_prev_ff) begin
               nxt_mode = wsirq_pkg::MODE_POWUP;
               nxt_src  = wsirq_pkg::SRC_KEY;
            end else if (wake_rise) begin
               nxt_mode = wsirq_pkg::MODE_POWUP;
               nxt_src  = wsirq_pkg::SRC_WAKE;
            end
         end
         wsirq_pkg::MODE_POWUP: begin
            if (src_ff == wsirq_pkg::SRC_KEY && key_wake_pin_n_in) begin
               nxt_mode = wsirq_pkg::MODE_OFF;
            end else if (src_ff == wsirq_pkg::SRC_WAKE && !wake_pin_in) begin
               nxt_mode = wsirq_pkg::MODE_OFF;
            end else if (supply_osc_ready_in) begin
               nxt_mode = wsirq_pkg::MODE_ACTIVE;
               nxt_irq  = 1'b1;
               nxt_status.ram_supply_lost = 1'b1;
               if (src_ff == wsirq_pkg::SRC_KEY) begin
                  nxt_status.key_status = 1'b1;
               end else begin
                  nxt_status.wake_flag = 1'b1;
               end
            end
         end
         wsirq_pkg::MODE_ACTIVE: begin
            // Pin releases are ignored here; only the OFF command leaves
            if (cmd_valid_in && cmd_type == wsirq_pkg::CMD_OFF
                && !wake_pin_in && key_wake_pin_n_in) begin
               nxt_mode = wsirq_pkg::MODE_OFF;
            end
            if (key_edge) begin
               nxt_deb_run = !deb_run_ff;
               nxt_deb_cnt = '0;
            end else if (deb_run_ff) begin
               if (deb_cnt_ff == DEB_LAST) begin
                  nxt_deb_run = 1'b0;
                  nxt_status.key_status = !key_wake_pin_n_in;
                  nxt_irq = 1'b1;
               end else begin
                  nxt_deb_cnt = deb_cnt_ff + 1'b1;
               end
            end
            if (wake_rise) begin
               nxt_dly_run = 1'b1;
               nxt_dly_cnt = '0;
            end else if (dly_run_ff) begin
               if (dly_cnt_ff == DLY_LAST) begin
                  nxt_dly_run = 1'b0;
                  nxt_status.wake_flag = 1'b1;
                  if (!status_ff.wake_flag) begin
                     nxt_irq = 1'b1;
                  end
               end else begin
                  nxt_dly_cnt = dly_cnt_ff + 1'b1;
               end
            end
         end
         default: nxt_mode = wsirq_pkg::MODE_OFF;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pwr_cfg_ff   <= '{wsirq_pkg::PWR_FE_RST, wsirq_pkg::PWR_SEL_RST, wsirq_pkg::PWR_CODE_RST};
         status_ff    <= '0;
         mode_ff      <= wsirq_pkg::MODE_OFF;
         src_ff       <= wsirq_pkg::SRC_NONE;
         irq_ff       <= 1'b0;
         key_prev_ff  <= 1'b1;
         wake_prev_ff <= 1'b0;
         deb_run_ff   <= 1'b0;
         deb_cnt_ff   <= '0;
         dly_run_ff   <= 1'b0;
         dly_cnt_ff   <= '0;
         rd_data_ff   <= 8'h00;
         rd_valid_ff  <= 1'b0;
      end else begin
         pwr_cfg_ff   <= nxt_pwr_cfg;
         status_ff    <= nxt_status;
         mode_ff      <= nxt_mode;
         src_ff       <= nxt_src;
         irq_ff       <= nxt_irq;
         key_prev_ff  <= nxt_key_prev;
         wake_prev_ff <= nxt_wake_prev;
         deb_run_ff   <= nxt_deb_run;
         deb_cnt_ff   <= nxt_deb_cnt;
         dly_run_ff   <= nxt_dly_run;
         dly_cnt_ff   <= nxt_dly_cnt;
         rd_data_ff   <= nxt_rd_data;
         rd_valid_ff  <= nxt_rd_valid;
      end
   end

   assign rd_data_out     = rd_data_ff;
   assign rd_valid_out    = rd_valid_ff;
   assign irq_out         = irq_ff;
   assign supplies_on_out = mode_ff != wsirq_pkg::MODE_OFF;
   assign active_mode_out = mode_ff == wsirq_pkg::MODE_ACTIVE;
   assign clk_out_en_out  = active_mode_out
                            && (clk_on_sw_in || status_ff.wake_flag || deb_run_ff);
   assign use_code_resistor_out = full_duplex_mode_in
                                  || (tx_mode_in && pwr_cfg_ff.power_resistor_select);
   assign power_reduce_resistor_out = pwr_cfg_ff.power_resistor_code;

endmodule : wsirq_logic

// ==== testbench/wsirq_logic_asserts.sv ====
`timescale 1ns/1ps
module wsirq_logic_asserts #(
   parameter int DEBOUNCE_CYC = 8195
) (
   input wire logic       core_clk_in,          // Clock
   input wire logic       arst_n_in,            // Reset
   input wire logic       cmd_valid_in,         // Command strobe
   input wire logic [7:0] cmd_byte_in,          // Command
   input wire logic       key_wake_pin_n_in,    // Key pin
   input wire logic       wake_pin_in,          // Wake pin
   input wire logic       tx_mode_in,           // TX mode
   input wire logic       full_duplex_mode_in,  // Duplex mode
   input wire logic       rd_valid_out,         // Read strobe
   input wire logic       irq_out,              // Interrupt
   input wire logic       supplies_on_out,      // Supplies
   input wire logic       active_mode_out,      // Active
   input wire logic       clk_out_en_out,       // Clock enable
   input wire logic       use_code_resistor_out // Code in use
);
   logic [2:0] typ;
   assign typ = cmd_byte_in[7:5];
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   a_read_answer: assert property (cmd_valid_in && typ == wsirq_pkg::CMD_RD_REG |=> rd_valid_out)
      else $error("register read got no answer");
   a_read_only: assert property (!(cmd_valid_in && typ == wsirq_pkg::CMD_RD_REG) |=> !rd_valid_out)
      else $error("read strobe without a read command");
   a_status_clr: assert property (cmd_valid_in && cmd_byte_in == {wsirq_pkg::CMD_RD_REG, wsirq_pkg::ADDR_STATUS}
      |=> !irq_out)
      else $error("status read left interrupt set");
   a_irq_clear: assert property (cmd_valid_in && typ == wsirq_pkg::CMD_IRQ_CLR |=> !irq_out)
      else $error("clear command left interrupt set");
   a_irq_level: assert property (irq_out && !cmd_valid_in |=> irq_out)
      else $error("interrupt dropped without a command");
   a_code_duplex: assert property (full_duplex_mode_in |-> use_code_resistor_out)
      else $error("duplex mode not using resistor code");
   a_code_idle: assert property (!full_duplex_mode_in && !tx_mode_in |-> !use_code_resistor_out)
      else $error("resistor code used outside TX and duplex");
   a_stay_on: assert property (active_mode_out && !(cmd_valid_in && typ == wsirq_pkg::CMD_OFF)
      |=> supplies_on_out)
      else $error("supplies dropped without off command");
   a_clk_gate: assert property (!active_mode_out |-> !clk_out_en_out)
      else $error("clock output enabled while not active");
   a_key_wake: assert property (!supplies_on_out && $fell(key_wake_pin_n_in) |=> supplies_on_out)
      else $error("key fall did not start supplies");
   a_pin_wake: assert property (!supplies_on_out && $rose(wake_pin_in) |=> supplies_on_out)
      else $error("wake rise did not start supplies");
endmodule : wsirq_logic_asserts

bind wsirq_logic wsirq_logic_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) wsirq_logic_asserts_i (.core_clk_in,
   .arst_n_in, .cmd_valid_in, .cmd_byte_in, .key_wake_pin_n_in, .wake_pin_in, .tx_mode_in, .full_duplex_mode_in,
   .rd_valid_out, .irq_out, .supplies_on_out, .active_mode_out, .clk_out_en_out, .use_code_resistor_out);

// ==== testbench/wsirq_host.sv ====
`timescale 1ns/1ps
module wsirq_host (
   input  wire logic       core_clk_in,   // Clock
   output logic            cmd_valid_out, // Command strobe
   output logic      [7:0] cmd_byte_out,  // Command byte
   output logic      [7:0] cmd_wdata_out  // Write data
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_byte_out  = 8'h00;
      cmd_wdata_out = 8'h00;
   end
   // One command byte and one data byte per transfer, type in the top bits
   task automatic send(input logic [7:0] cmd, input logic [7:0] dat);
      @(negedge core_clk_in);
      cmd_valid_out = 1'b1;
      cmd_byte_out  = cmd;
      cmd_wdata_out = dat;
      @(negedge core_clk_in);
      cmd_valid_out = 1'b0;
      // Idle lines do not keep the last value, so stale data cannot pass
      cmd_byte_out  = ~cmd;
      cmd_wdata_out = ~dat;
   endtask : send
endmodule : wsirq_host

// ==== testbench/wsirq_logic_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module wsirq_logic_tb;
   localparam int DEB = 20;
   logic       clk, rst_n, cv, key_n, wake, low, rdy, tx, fd, sw, rv, irq, sup, act, ce, uc;
   logic [7:0] cb, wd, rdd, e_nx;
   logic [4:0] pr;
   logic [7:0] exp_q[$];
   int         error_cnt = 0;
   int         cmp_count = 0;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   wsirq_logic #(.DEBOUNCE_CYC(DEB)) wsirq_logic_i (.core_clk_in(clk), .arst_n_in(rst_n), .cmd_valid_in(cv),
      .cmd_byte_in(cb), .cmd_wdata_in(wd), .key_wake_pin_n_in(key_n), .wake_pin_in(wake), .ram_supply_low_in(low),
      .supply_osc_ready_in(rdy), .tx_mode_in(tx), .full_duplex_mode_in(fd), .clk_on_sw_in(sw), .rd_data_out(rdd),
      .rd_valid_out(rv), .irq_out(irq), .supplies_on_out(sup), .active_mode_out(act), .clk_out_en_out(ce),
      .use_code_resistor_out(uc), .power_reduce_resistor_out(pr));
   wsirq_host wsirq_host_i (.core_clk_in(clk), .cmd_valid_out(cv), .cmd_byte_out(cb), .cmd_wdata_out(wd));

   task automatic results;
      $display("Counts: errors=%0d checks=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      wsirq_host_i.send({wsirq_pkg::CMD_RD_REG, a}, 8'h00);
      @(negedge clk);
   endtask : rd

   task automatic rds(input logic [7:0] e);
      rd(wsirq_pkg::ADDR_STATUS, e);
   endtask : rds

   task automatic wirq(input int lim);
      int i;
      for (i = 0; i < lim && irq !== 1'b1; i++) @(negedge clk);
      `CHK("irq", 1'b1, irq)
      if (irq !== 1'b1) results();
   endtask : wirq

   // Read data is checked against the oldest expectation when the strobe shows
   always @(negedge clk) begin
      if (rv === 1'b1) begin
         if (exp_q.size() == 0) begin
            error_cnt++;
            $display("[ERR] rd_data exp=none got=%h", rdd);
         end else begin
            e_nx = exp_q.pop_front();
            `CHK("rd_data", e_nx, rdd)
         end
      end
   end

   initial begin
      logic [4:0] code;
      logic       sel;
      int         k;
      void'($urandom(65830));
      {rst_n, key_n, wake, low, rdy, tx, fd, sw} = 8'h40;
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      rd(wsirq_pkg::ADDR_TX_PWR, 8'h50);
      rds(8'h00);
      rd(5'h08 + 5'($urandom % 8), 8'h00);
      $display("test reset values done");
      key_n = 1'b0; cyc(3); `CHK("sup", 1'b1, sup)
      key_n = 1'b1; cyc(3); `CHK("sup", 1'b0, sup)
      wake = 1'b1; cyc(3); `CHK("sup", 1'b1, sup)
      wake = 1'b0; cyc(3); `CHK("sup", 1'b0, sup)
      rdy = 1'b1; key_n = 1'b0; wirq(10); `CHK("act", 1'b1, act)
      // Software clock enable must pass through once active
      sw = 1'b1; cyc(1); `CHK("clk_en", 1'b1, ce)
      sw = 1'b0;
      rds(8'h05);
      `CHK("irq", 1'b0, irq)
      $display("test wake from off done");
      key_n = 1'b1; cyc(2); `CHK("clk_en", 1'b1, ce)
      cyc(DEB - 3); `CHK("irq", 1'b0, irq)
      wirq(5); rds(8'h00);
      key_n = 1'b0; cyc(5); key_n = 1'b1; cyc(DEB + 10); `CHK("irq", 1'b0, irq)
      rds(8'h00);
      $display("test debounce done");
      low = 1'b1; rds(8'h04); low = 1'b0; rds(8'h04); rds(8'h00);
      $display("test supply flag done");
      wake = 1'b1; cyc(4); `CHK("irq", 1'b0, irq)
      wirq(4);
      wsirq_host_i.send({wsirq_pkg::CMD_IRQ_CLR, 5'h00}, 8'h00); cyc(1); `CHK("irq", 1'b0, irq)
      `CHK("clk_en", 1'b1, ce)
      wake = 1'b0; cyc(2); wake = 1'b1; cyc(10); `CHK("irq", 1'b0, irq)
      rds(8'h02); `CHK("clk_en", 1'b0, ce)
      $display("test wake pin done");
      for (k = 0; k < 4; k++) begin
         code = 5'($urandom);
         sel = k[0];
         wsirq_host_i.send({wsirq_pkg::CMD_WR_REG, wsirq_pkg::ADDR_TX_PWR}, {2'b01, sel, code});
         wsirq_host_i.send({wsirq_pkg::CMD_WR_REG, 5'h08}, 8'hFF);
         rd(wsirq_pkg::ADDR_TX_PWR, {2'b01, sel, code});
         `CHK("code", code, pr)
         tx = 1'b1; cyc(1); `CHK("use_code", sel, uc)
         fd = 1'b1; cyc(1); `CHK("use_code", 1'b1, uc)
         tx = 1'b0; fd = 1'b0;
      end
      $display("test power config done");
      // Wake pin still high: the off command must be refused
      wsirq_host_i.send({wsirq_pkg::CMD_OFF, 5'h00}, 8'h00); cyc(2); `CHK("sup", 1'b1, sup)
      wake = 1'b0; cyc(1);
      wsirq_host_i.send({wsirq_pkg::CMD_OFF, 5'h00}, 8'h00); cyc(2); `CHK("sup", 1'b0, sup)
      wake = 1'b1; wirq(10); rds(8'h06);
      $display("test off and rewake done");
      results();
   end
endmodule : wsirq_logic_tb
